/* File: core/routing_pkg.sv */
package routing_pkg;
    // -------------------------------------------------------------
    // register map (word indices, taken from byte address bits 3:2)
    // -------------------------------------------------------------
    localparam int AXI_AW = 4;
    localparam logic [1:0] IDX_CTRL0 = 2'h0;
    localparam logic [1:0] IDX_CTRL1 = 2'h1;
    localparam logic [1:0] IDX_CTRL2 = 2'h2;
    localparam logic [1:0] IDX_CTRL3 = 2'h3;
    localparam logic [7:0] MASK_CTRL0 = 8'hff;
    localparam logic [7:0] MASK_CTRL1 = 8'hc7;
    localparam logic [7:0] MASK_CTRL2 = 8'h88;
    localparam logic [7:0] MASK_CTRL3 = 8'h1e;
    localparam logic [7:0] RESET_CTRL = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int F_TWOWIRE_HI = 7;
    localparam int F_TWOWIRE_LO = 6;
    localparam int F_ASYNC1 = 5;
    localparam int F_ASYNC0 = 4;
    localparam int F_SYNCSER = 3;
    localparam int F_CAN_HI = 2;
    localparam int F_T1CAP3 = 7;
    localparam int F_T1CAP2 = 6;
    localparam int F_TRIG_FALL = 2;
    localparam int F_TRIG_HI = 1;
    localparam int F_PWM7 = 7;
    localparam int F_PWM3 = 3;
    localparam int F_T0CAP3_INT = 4;
    localparam int F_T0CAP3_PIN = 3;
    localparam int F_T0CAP2 = 2;
    localparam int F_T0CAP1 = 1;
    // -------------------------------------------------------------
    // codes
    // -------------------------------------------------------------
    localparam logic [1:0] TW_ON_T = 2'h2;
    localparam logic [1:0] TW_ON_S = 2'h1;
    localparam logic [1:0] TW_ON_J = 2'h0;
    localparam logic [1:0] TRIG_PP4 = 2'h3;
    localparam logic [1:0] TRIG_PAD1 = 2'h2;
    localparam logic [1:0] TRIG_PAD15 = 2'h1;
    localparam logic [1:0] TRIG_CMP2 = 2'h0;
    // can field bits: 0 direct bit, 1 link opened, 2 link on pins
    localparam int CAN_DIRECT = 0;
    localparam int CAN_OPEN = 1;
    localparam int CAN_PINS = 2;
    // -------------------------------------------------------------
    // synchronised pin vector layout
    // -------------------------------------------------------------
    localparam int PIN_W = 32;
    localparam int PT_LO = 0;
    localparam int PS_LO = 8;
    localparam int PJ_LO = 16;
    localparam int PP_LO = 18;
    localparam int PAD1_BIT = 26;
    localparam int PAD15_BIT = 27;
    localparam int CAN_LO = 28;
endpackage : routing_pkg

/* File: core/peripheral_signal_routing.sv */
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
// Behaviour
// - reserved bits ignore writes, read zero
// - control 0 and 2 write-once in normal mode
// - control 1 and 3 writable any time
// - two-wire pins on T, S or J
// - second async channel on T1/T0 or S5/S4
// - first async channel on S1/S0 or J1/J0
// - synchronous port on T4-7 or S0-3
// - can link modes: internal, direct, probe, open
// - can pin drive needs its unit enabled
// - second timer capture 3 from comparator b
// - second timer capture 2 from comparator a
// - trigger polarity bit selects falling edge
// - trigger source from P4, pad1, pad15, compare2
// - compare2 pin active unless its disable set
// - pwm channel 7 on T3 or P3
// - pwm channel 3 on T2 or P1
// - first timer capture 3 from S4 or internal
// - internal capture 3 source picks receive line
// - first timer capture 2 from S5 or aux clock
// - first timer capture 1 from S6 or S7
// - register reads synchronous to the clock
module peripheral_signal_routing (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic special_mode_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [routing_pkg::AXI_AW-1:0] s_awaddr_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    output logic [1:0] s_bresp_o,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    input wire logic [routing_pkg::AXI_AW-1:0] s_araddr_i,
    output logic s_rvalid_o,
    input wire logic s_rready_i,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    input wire logic [7:0] pt_i,
    output logic [7:0] pt_o,
    output logic [7:0] pt_oe_o,
    input wire logic [7:0] ps_i,
    output logic [7:0] ps_o,
    output logic [7:0] ps_oe_o,
    input wire logic [1:0] pj_i,
    output logic [1:0] pj_o,
    output logic [1:0] pj_oe_o,
    input wire logic [7:0] pp_i,
    output logic [7:0] pp_o,
    output logic [7:0] pp_oe_o,
    input wire logic pad1_i,
    input wire logic pad15_i,
    input wire logic [3:0] can_pin_i,
    output logic [3:0] can_pin_o,
    output logic [3:0] can_pin_oe_o,
    input wire logic scl_drive_low_i,
    input wire logic sda_drive_low_i,
    output logic scl_in_o,
    output logic sda_in_o,
    input wire logic async1_tx_i,
    output logic async1_rx_o,
    input wire logic async0_tx_i,
    output logic async0_rx_o,
    input wire logic [3:0] syncser_out_i,
    input wire logic [3:0] syncser_oe_i,
    output logic [3:0] syncser_in_o,
    input wire logic can_controller_enable_i,
    input wire logic transceiver_enable_i,
    input wire logic controller_tx_out_i,
    output logic controller_rx_in_o,
    input wire logic transceiver_rx_out_i,
    input wire logic transceiver_direct_bit_i,
    output logic transceiver_tx_in_o,
    input wire logic analog_comparator_a_i,
    input wire logic analog_comparator_b_i,
    output logic second_timer_cap3_o,
    output logic second_timer_cap2_o,
    input wire logic first_timer_cmp2_i,
    input wire logic compare2_pin_disable_i,
    output logic cmp2_pin_oe_o,
    output logic conv_trig_o,
    input wire logic pwm_ch7_i,
    input wire logic pwm_ch3_i,
    input wire logic aux_clk_i,
    output logic first_timer_cap3_o,
    output logic first_timer_cap2_o,
    output logic first_timer_cap1_o
);
    import routing_pkg::*;

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] ctrl3;
        logic lock0;
        logic lock2;
        logic aw_held;
        logic [AXI_AW-1:0] aw_addr;
        logic w_held;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [PIN_W-1:0] sync1;
        logic [PIN_W-1:0] sync2;
        logic [PIN_W-1:0] sync3;
        logic [PIN_W-1:0] pin_f;
        logic [7:0] pt_out;
        logic [7:0] pt_oe;
        logic [7:0] ps_out;
        logic [7:0] ps_oe;
        logic [1:0] pj_out;
        logic [1:0] pj_oe;
        logic [7:0] pp_out;
        logic [7:0] pp_oe;
        logic [3:0] can_out;
        logic [3:0] can_oe;
        logic scl_in;
        logic sda_in;
        logic a1_rx;
        logic a0_rx;
        logic [3:0] ss_in;
        logic ctl_rx;
        logic xcvr_tx;
        logic t1cap3;
        logic t1cap2;
        logic cmp2_oe;
        logic trig;
        logic t0cap3;
        logic t0cap2;
        logic t0cap1;
    } state_t;

    state_t s;
    state_t next_s;

    // {hit, index} for an address
    function automatic logic [2:0] decode(input logic [AXI_AW-1:0] a);
        logic [2:0] r;
        r = 3'h0;
        if (a[1:0] != 2'h0) r = 3'h0;
        else if (a[3:2] == IDX_CTRL0) r = {1'b1, IDX_CTRL0};
        else if (a[3:2] == IDX_CTRL1) r = {1'b1, IDX_CTRL1};
        else if (a[3:2] == IDX_CTRL2) r = {1'b1, IDX_CTRL2};
        else r = {1'b1, IDX_CTRL3};
        return r;
    endfunction : decode

    // -------------------------------------------------------------
    // bus helpers
    // -------------------------------------------------------------
    logic aw_take, w_take, have_aw, have_w, do_wr, wr_en;
    logic [AXI_AW-1:0] wr_addr;
    logic [7:0] wr_data, rd_val;
    logic [2:0] wr_dec, rd_dec;
    logic [7:0] pt_in, ps_in, pp_in;
    logic [1:0] pj_in;
    logic [3:0] can_in;
    logic a1_rx_w, a0_rx_w, trig_raw;

    assign s_awready_o = !s.aw_held && !s.bvalid;
    assign s_wready_o = !s.w_held && !s.bvalid;
    assign s_arready_o = !s.rvalid;
    assign aw_take = s_awvalid_i && s_awready_o;
    assign w_take = s_wvalid_i && s_wready_o;
    assign have_aw = s.aw_held || aw_take;
    assign have_w = s.w_held || w_take;
    assign do_wr = have_aw && have_w;
    assign wr_addr = s.aw_held ? s.aw_addr : s_awaddr_i;
    assign wr_data = s.w_held ? s.wdata : s_wdata_i[7:0];
    assign wr_en = do_wr && (s.w_held ? s.wstrb0 : s_wstrb_i[0]);
    assign wr_dec = decode(wr_addr);
    assign rd_dec = decode(s_araddr_i);
    assign pt_in = s.pin_f[PT_LO +: 8];
    assign ps_in = s.pin_f[PS_LO +: 8];
    assign pj_in = s.pin_f[PJ_LO +: 2];
    assign pp_in = s.pin_f[PP_LO +: 8];
    assign can_in = s.pin_f[CAN_LO +: 4];

    always_comb begin
        rd_val = 8'h00;
        if (rd_dec[1:0] == IDX_CTRL0) rd_val = s.ctrl0;
        else if (rd_dec[1:0] == IDX_CTRL1) rd_val = s.ctrl1;
        else if (rd_dec[1:0] == IDX_CTRL2) rd_val = s.ctrl2;
        else rd_val = s.ctrl3;
    end

    // internal receive lines follow the async routing bits
    assign a1_rx_w = s.ctrl0[F_ASYNC1] ? pt_in[0] : ps_in[4];
    assign a0_rx_w = s.ctrl0[F_ASYNC0] ? ps_in[0] : pj_in[0];

    always_comb begin
        case (s.ctrl1[F_TRIG_HI -: 2])
            TRIG_PP4: trig_raw = pp_in[4];
            TRIG_PAD1: trig_raw = s.pin_f[PAD1_BIT];
            TRIG_PAD15: trig_raw = s.pin_f[PAD15_BIT];
            default: trig_raw = first_timer_cmp2_i;
        endcase
    end

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        logic [PIN_W-1:0] agree;
        logic [2:0] cm;
        agree = '0;
        cm = 3'h0;
        next_s = s;
        // pins: three stages, a change counts once stages 2 and 3 agree
        next_s.sync1 = {can_pin_i, pad15_i, pad1_i, pp_i, pj_i, ps_i, pt_i};
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        agree = ~(s.sync2 ^ s.sync3);
        next_s.pin_f = (agree & s.sync3) | (~agree & s.pin_f);

        // write channel: address and data in either order
        if (aw_take) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_awaddr_i;
        end
        if (w_take) begin
            next_s.w_held = 1'b1;
            next_s.wdata = s_wdata_i[7:0];
            next_s.wstrb0 = s_wstrb_i[0];
        end
        if (do_wr) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = wr_dec[2] ? RESP_OKAY : RESP_SLVERR;
        end
        if (s.bvalid && s_bready_i) next_s.bvalid = 1'b0;
        if (wr_en && wr_dec[2]) begin
            if (wr_dec[1:0] == IDX_CTRL0) begin
                // locked writes still answer okay, the value stays
                if (special_mode_i || !s.lock0) begin
                    next_s.ctrl0 = wr_data & MASK_CTRL0;
                    next_s.lock0 = s.lock0 || !special_mode_i;
                end
            end else if (wr_dec[1:0] == IDX_CTRL1) begin
                next_s.ctrl1 = wr_data & MASK_CTRL1;
            end else if (wr_dec[1:0] == IDX_CTRL2) begin
                if (special_mode_i || !s.lock2) begin
                    next_s.ctrl2 = wr_data & MASK_CTRL2;
                    next_s.lock2 = s.lock2 || !special_mode_i;
                end
            end else begin
                next_s.ctrl3 = wr_data & MASK_CTRL3;
            end
        end

        // read channel: data registered on the clock
        if (s_arvalid_i && s_arready_o) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_dec[2] ? rd_val : 8'h00;
            next_s.rresp = rd_dec[2] ? RESP_OKAY : RESP_SLVERR;
        end else if (s.rvalid && s_rready_i) begin
            next_s.rvalid = 1'b0;
        end

        // pin drivers: later assignments take the shared pin
        next_s.pt_out = 8'h00;
        next_s.pt_oe = 8'h00;
        next_s.ps_out = 8'h00;
        next_s.ps_oe = 8'h00;
        next_s.pj_out = 2'h0;
        next_s.pj_oe = 2'h0;
        next_s.pp_out = 8'h00;
        next_s.pp_oe = 8'h00;
        for (int k = 0; k < 4; k++) begin
            if (s.ctrl0[F_SYNCSER]) begin
                next_s.pt_out[4+k] = syncser_out_i[k];
                next_s.pt_oe[4+k] = syncser_oe_i[k];
                next_s.ss_in[k] = pt_in[4+k];
            end else begin
                next_s.ps_out[k] = syncser_out_i[k];
                next_s.ps_oe[k] = syncser_oe_i[k];
                next_s.ss_in[k] = ps_in[k];
            end
        end
        if (s.ctrl0[F_ASYNC0]) begin
            next_s.ps_out[1] = async0_tx_i;
            next_s.ps_oe[1] = 1'b1;
        end else begin
            next_s.pj_out[1] = async0_tx_i;
            next_s.pj_oe[1] = 1'b1;
        end
        next_s.a0_rx = a0_rx_w;
        if (s.ctrl0[F_ASYNC1]) begin
            next_s.pt_out[1] = async1_tx_i;
            next_s.pt_oe[1] = 1'b1;
        end else begin
            next_s.ps_out[5] = async1_tx_i;
            next_s.ps_oe[5] = 1'b1;
        end
        next_s.a1_rx = a1_rx_w;
        if (s.ctrl2[F_PWM7]) begin
            next_s.pt_out[3] = pwm_ch7_i;
            next_s.pt_oe[3] = 1'b1;
        end else begin
            next_s.pp_out[3] = pwm_ch7_i;
            next_s.pp_oe[3] = 1'b1;
        end
        if (s.ctrl2[F_PWM3]) begin
            next_s.pt_out[2] = pwm_ch3_i;
            next_s.pt_oe[2] = 1'b1;
        end else begin
            next_s.pp_out[1] = pwm_ch3_i;
            next_s.pp_oe[1] = 1'b1;
        end
        // open drain: drive low only; reserved code leaves bus idle high
        next_s.scl_in = 1'b1;
        next_s.sda_in = 1'b1;
        case (s.ctrl0[F_TWOWIRE_HI:F_TWOWIRE_LO])
            TW_ON_T: begin
                next_s.pt_out[1:0] = 2'h0;
                next_s.pt_oe[1:0] = {scl_drive_low_i, sda_drive_low_i};
                next_s.scl_in = pt_in[1];
                next_s.sda_in = pt_in[0];
            end
            TW_ON_S: begin
                next_s.ps_out[1:0] = 2'h0;
                next_s.ps_oe[1:0] = {scl_drive_low_i, sda_drive_low_i};
                next_s.scl_in = ps_in[1];
                next_s.sda_in = ps_in[0];
            end
            TW_ON_J: begin
                next_s.pj_out = 2'h0;
                next_s.pj_oe = {scl_drive_low_i, sda_drive_low_i};
                next_s.scl_in = pj_in[1];
                next_s.sda_in = pj_in[0];
            end
            default: begin
            end
        endcase

        // can link: pins 0 ctl tx, 1 ctl rx, 2 xcvr tx, 3 xcvr rx
        cm = s.ctrl0[F_CAN_HI:0];
        next_s.can_out = {transceiver_rx_out_i, 1'b0, 1'b0, controller_tx_out_i};
        next_s.can_oe = 4'h0;
        if (cm[CAN_OPEN]) begin
            next_s.xcvr_tx = can_in[2];
            next_s.ctl_rx = can_in[1];
            next_s.can_oe[0] = can_controller_enable_i;
            next_s.can_oe[3] = transceiver_enable_i;
        end else begin
            next_s.xcvr_tx = cm[CAN_DIRECT] ? transceiver_direct_bit_i
                                            : controller_tx_out_i;
            next_s.ctl_rx = transceiver_rx_out_i;
            if (cm[CAN_PINS]) begin
                // probe shows the tx and rx legs of the internal link
                next_s.can_out[1] = transceiver_rx_out_i;
                next_s.can_oe[1] = transceiver_enable_i;
                next_s.can_out[0] = cm[CAN_DIRECT] ? transceiver_direct_bit_i
                                                   : controller_tx_out_i;
                next_s.can_oe[0] = cm[CAN_DIRECT] ? transceiver_enable_i
                                                  : can_controller_enable_i;
            end
        end

        // capture and trigger sources
        next_s.t1cap3 = s.ctrl1[F_T1CAP3] ? analog_comparator_b_i : pt_in[3];
        next_s.t1cap2 = s.ctrl1[F_T1CAP2] ? analog_comparator_a_i : pt_in[2];
        next_s.trig = trig_raw ^ s.ctrl1[F_TRIG_FALL];
        next_s.cmp2_oe = !compare2_pin_disable_i;
        if (s.ctrl3[F_T0CAP3_PIN]) next_s.t0cap3 = ps_in[4];
        else next_s.t0cap3 = s.ctrl3[F_T0CAP3_INT] ? a1_rx_w : a0_rx_w;
        next_s.t0cap2 = s.ctrl3[F_T0CAP2] ? ps_in[5] : aux_clk_i;
        next_s.t0cap1 = s.ctrl3[F_T0CAP1] ? ps_in[6] : ps_in[7];
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '0;
            s.ctrl0 <= RESET_CTRL;
            s.ctrl1 <= RESET_CTRL;
            s.ctrl2 <= RESET_CTRL;
            s.ctrl3 <= RESET_CTRL;
            s.scl_in <= 1'b1;
            s.sda_in <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign s_bvalid_o = s.bvalid;
    assign s_bresp_o = s.bresp;
    assign s_rvalid_o = s.rvalid;
    assign s_rdata_o = {24'h00_0000, s.rdata};
    assign s_rresp_o = s.rresp;
    assign pt_o = s.pt_out;
    assign pt_oe_o = s.pt_oe;
    assign ps_o = s.ps_out;
    assign ps_oe_o = s.ps_oe;
    assign pj_o = s.pj_out;
    assign pj_oe_o = s.pj_oe;
    assign pp_o = s.pp_out;
    assign pp_oe_o = s.pp_oe;
    assign can_pin_o = s.can_out;
    assign can_pin_oe_o = s.can_oe;
    assign scl_in_o = s.scl_in;
    assign sda_in_o = s.sda_in;
    assign async1_rx_o = s.a1_rx;
    assign async0_rx_o = s.a0_rx;
    assign syncser_in_o = s.ss_in;
    assign controller_rx_in_o = s.ctl_rx;
    assign transceiver_tx_in_o = s.xcvr_tx;
    assign second_timer_cap3_o = s.t1cap3;
    assign second_timer_cap2_o = s.t1cap2;
    assign cmp2_pin_oe_o = s.cmp2_oe;
    assign conv_trig_o = s.trig;
    assign first_timer_cap3_o = s.t0cap3;
    assign first_timer_cap2_o = s.t0cap2;
    assign first_timer_cap1_o = s.t0cap1;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    lock_holds_a: assert property (s.lock0 && !special_mode_i |=> $stable(s.ctrl0))
        else $error("locked control 0 changed");
    first_write_a: assert property (wr_en && wr_dec == {1'b1, IDX_CTRL2} && !s.lock2
        |=> s.ctrl2 == ($past(wr_data) & MASK_CTRL2) && s.lock2 == !$past(special_mode_i)
            || s.lock2)
        else $error("first control 2 write lost");
    any_write_a: assert property (wr_en && wr_dec == {1'b1, IDX_CTRL3}
        |=> s.ctrl3 == ($past(wr_data) & MASK_CTRL3))
        else $error("control 3 write lost");
    reserved_zero_a: assert property (s_rvalid_o |-> ((s.ctrl1 & ~MASK_CTRL1) == 8'h00)
        && ((s.ctrl2 & ~MASK_CTRL2) == 8'h00) && ((s.ctrl3 & ~MASK_CTRL3) == 8'h00))
        else $error("reserved bit set");
    read_data_a: assert property (s_arvalid_i && s_arready_o && rd_dec[2]
        |=> s_rvalid_o && s_rdata_o[7:0] == $past(rd_val))
        else $error("read data wrong");
    trig_path_a: assert property (1'b1 |=> conv_trig_o == ($past(trig_raw) ^
        $past(s.ctrl1[F_TRIG_FALL])))
        else $error("trigger polarity wrong");
    can_gate_a: assert property (!can_controller_enable_i |=> !can_pin_oe_o[0]
        || $past(s.ctrl0[CAN_DIRECT] && !s.ctrl0[CAN_OPEN]))
        else $error("controller tx on pin while disabled");
    twowire_t_a: assert property (s.ctrl0[F_TWOWIRE_HI:F_TWOWIRE_LO] == TW_ON_T
        |=> pt_oe_o[1] == $past(scl_drive_low_i) && !pt_o[1])
        else $error("two-wire clock not on port t");
    cap3_src_a: assert property (!s.ctrl3[F_T0CAP3_PIN] |=> first_timer_cap3_o ==
        ($past(s.ctrl3[F_T0CAP3_INT]) ? $past(a1_rx_w) : $past(a0_rx_w)))
        else $error("capture 3 internal source wrong");

    locked_write_c: cover property (wr_en && wr_dec[2] && s.lock0 && !special_mode_i);
    special_write_c: cover property (wr_en && s.lock2 && special_mode_i);
    can_open_c: cover property (s.ctrl0[F_CAN_HI:0] == 3'h6 && can_pin_oe_o[0]);
    read_back_c: cover property (s_rvalid_o && s_rready_i);
endmodule : peripheral_signal_routing

/* File: bench/pin_model.sv */
`timescale 1ns/100ps
module pin_model (
    input wire logic [7:0] drv_i,
    input wire logic [7:0] out_i,
    input wire logic [7:0] oe_i,
    output logic [7:0] pin_o
);
    // a released pin shows the far side's own level, never the last driven one
    assign pin_o = (oe_i & out_i) | (~oe_i & drv_i);
endmodule : pin_model

/* File: bench/peripheral_signal_routing_tb.sv */
`timescale 1ns/100ps
module peripheral_signal_routing_tb;
    import routing_pkg::*;
    logic clk_i = '0, arst_n_i = '0, special_mode_i = '0, s_awvalid_i = '0, s_wvalid_i = '0;
    logic s_bready_i = '0, s_arvalid_i = '0, s_rready_i = '0, s_awready_o, s_wready_o;
    logic s_bvalid_o, s_arready_o, s_rvalid_o, scl_in_o, sda_in_o, async1_rx_o, async0_rx_o;
    logic [3:0] s_awaddr_i = '0, s_araddr_i = '0, s_wstrb_i = 4'h1;
    logic [31:0] s_wdata_i = '0, s_rdata_o;
    logic [1:0] s_bresp_o, s_rresp_o, pj_i, pj_o, pj_oe_o;
    logic [7:0] pt_i, pt_o, pt_oe_o, ps_i, ps_o, ps_oe_o, pp_i, pp_o, pp_oe_o;
    logic [3:0] can_pin_i, can_pin_o, can_pin_oe_o, syncser_out_i, syncser_oe_i, syncser_in_o;
    logic pad1_i, pad15_i, scl_drive_low_i, sda_drive_low_i, async1_tx_i, async0_tx_i;
    logic can_controller_enable_i, transceiver_enable_i, controller_tx_out_i, controller_rx_in_o;
    logic transceiver_rx_out_i, transceiver_direct_bit_i, transceiver_tx_in_o;
    logic analog_comparator_a_i, analog_comparator_b_i, second_timer_cap3_o, second_timer_cap2_o;
    logic first_timer_cmp2_i, compare2_pin_disable_i, cmp2_pin_oe_o, conv_trig_o, pwm_ch7_i;
    logic pwm_ch3_i, aux_clk_i, first_timer_cap3_o, first_timer_cap2_o, first_timer_cap1_o;
    logic [63:0] rnd = '0;
    logic [7:0] msk[4] = '{8'hff, 8'hc7, 8'h88, 8'h1e};
    int seed = 32'h7e34_c233, err_count = 0, samples_checked = 0;
    int mdl[4] = '{0, 0, 0, 0}, lk[4] = '{0, 0, 0, 0};
    wire logic [2:0] t0c = {first_timer_cap1_o, first_timer_cap2_o, first_timer_cap3_o};
    assign {pj_i, pp_i, pad1_i, pad15_i, can_pin_i, scl_drive_low_i, sda_drive_low_i,
        async1_tx_i, async0_tx_i, syncser_out_i, syncser_oe_i, can_controller_enable_i,
        transceiver_enable_i, controller_tx_out_i, transceiver_rx_out_i,
        transceiver_direct_bit_i, analog_comparator_a_i, analog_comparator_b_i,
        first_timer_cmp2_i, compare2_pin_disable_i, pwm_ch7_i, pwm_ch3_i, aux_clk_i,
        ps_i} = rnd[47:0];
    pin_model pm (.drv_i(rnd[55:48]), .out_i(pt_o), .oe_i(pt_oe_o), .pin_o(pt_i));
    peripheral_signal_routing uut (.*);
    initial forever #10 clk_i = ~clk_i;
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task automatic tmo();
        err_count++;
        report_and_stop();
    endtask : tmo
    // --------
    // bus master
    // --------
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        logic ha, hw, hd;
        logic [1:0] r;
        logic [31:0] dt;
        @(posedge clk_i);
        {s_awaddr_i, s_araddr_i, s_wdata_i} <= {a, a, 24'h00_0000, d};
        {s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i} <= {w, w, w, !w, !w};
        hd = 0;
        for (int n = 0; n < 50 && !hd; n++) begin
            @(negedge clk_i);
            ha = w ? s_awready_o && s_awvalid_i : s_arready_o && s_arvalid_i;
            hw = s_wready_o && s_wvalid_i;
            hd = w ? s_bvalid_o : s_rvalid_o;
            {r, dt} = w ? {s_bresp_o, 32'h0000_0000} : {s_rresp_o, s_rdata_o};
            @(posedge clk_i);
            if (ha) {s_awvalid_i, s_arvalid_i} <= 2'h0;
            if (hw) s_wvalid_i <= 1'h0;
        end
        {s_bready_i, s_rready_i} <= 2'h0;
        if (!hd) tmo();
        chk("resp", r, a[1:0] ? RESP_SLVERR : RESP_OKAY);
        if (!w) chk("rdata", dt, a[1:0] ? 0 : mdl[a[3:2]]);
        if (w && a[1:0] == 2'h0) begin
            // lock only follows a normal-mode write to the even registers
            if (special_mode_i || a[2] || !lk[a[3:2]]) mdl[a[3:2]] = d & msk[a[3:2]];
            lk[a[3:2]] |= !special_mode_i && !a[2];
        end
    endtask : bus
    task automatic st();
        @(posedge clk_i);
        rnd <= {$random(seed), $random(seed)};
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
    endtask : st
    initial begin
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'h1;
        for (int i = 0; i < 16; i += 4) bus(0, i[3:0], 0);
        bus(1, 4'h0, 8'h20);
        bus(1, 4'h0, 8'h10);
        bus(0, 4'h0, 0);
        st();
        chk("async1 tx", pt_o[1], async1_tx_i);
        chk("async1 rx", async1_rx_o, pt_i[0]);
        chk("async0 rx", async0_rx_o, pj_i[0]);
        chk("syncser in", syncser_in_o, ps_i[3:0]);
        chk("scl in", scl_in_o, pj_i[1]);
        @(posedge clk_i);
        special_mode_i <= 1'h1;
        bus(1, 4'h8, 8'h80);
        bus(1, 4'h8, 8'hff);
        bus(0, 4'h8, 0);
        bus(1, 4'h4, 8'hff);
        bus(0, 4'h4, 0);
        st();
        chk("pwm7", pt_o[3], pwm_ch7_i);
        chk("pwm3", pt_o[2], pwm_ch3_i);
        chk("t1 cap3", second_timer_cap3_o, analog_comparator_b_i);
        chk("t1 cap2", second_timer_cap2_o, analog_comparator_a_i);
        chk("trig fall", conv_trig_o, !pp_i[4]);
        bus(1, 4'h4, 8'h00);
        bus(1, 4'hc, 8'h1e);
        bus(0, 4'hc, 0);
        st();
        chk("trig cmp", conv_trig_o, first_timer_cmp2_i);
        chk("cmp2 oe", cmp2_pin_oe_o, !compare2_pin_disable_i);
        chk("t1 pin3", second_timer_cap3_o, pt_i[3]);
        chk("t0 pins", t0c, ps_i[6:4]);
        bus(1, 4'hc, 8'h10);
        st();
        chk("t0 int", t0c, {ps_i[7], aux_clk_i, pt_i[0]});
        // standalone can on pins with two-wire moved to port t
        bus(1, 4'h0, 8'h86);
        bus(0, 4'h0, 0);
        st();
        chk("scl oe", pt_oe_o[1:0], {scl_drive_low_i, sda_drive_low_i});
        chk("scl out", pt_o[1:0], 2'h0);
        chk("can oe", can_pin_oe_o, {transceiver_enable_i, 2'h0, can_controller_enable_i});
        chk("xcvr tx", transceiver_tx_in_o, can_pin_i[2]);
        chk("ctl rx", controller_rx_in_o, can_pin_i[1]);
        bus(1, 4'h1, 8'h55);
        bus(0, 4'h6, 0);
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        tmo();
    end
endmodule : peripheral_signal_routing_tb
